// File: src/timer_pair_pkg.sv
package timer_pair_pkg;

	// -------------------------------------------------------------
	// Clock and tick rates
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int SYS_KHZ       = 1_000_000 / CLK_PERIOD_NS;
	localparam int FAST_KHZ      = 13_560;
	localparam int SLOW_KHZ      = 212;

	// -------------------------------------------------------------
	// Register offsets
	// -------------------------------------------------------------
	localparam logic [7:0] ADDR_B_RELOAD_HIGH = 8'h15;
	localparam logic [7:0] ADDR_B_RELOAD_LOW  = 8'h16;
	localparam logic [7:0] ADDR_B_COUNT_HIGH  = 8'h17;
	localparam logic [7:0] ADDR_B_COUNT_LOW   = 8'h18;
	localparam logic [7:0] ADDR_C_CONTROL     = 8'h19;
	localparam logic [7:0] ADDR_C_RELOAD_HIGH = 8'h1A;
	localparam logic [7:0] ADDR_C_RELOAD_LOW  = 8'h1B;
	localparam logic [7:0] ADDR_COMMAND       = 8'h30;
	localparam logic [7:0] ADDR_B_CONFIG      = 8'h31;
	localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h32;
	localparam logic [7:0] ADDR_IRQ_CLEAR     = 8'h33;
	localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h34;

	// -------------------------------------------------------------
	// Field positions, masks and reset values
	// -------------------------------------------------------------
	localparam logic [7:0] CTRL_WMASK  = 8'hBB;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam int CMD_START_B = 0;
	localparam int CMD_STOP_B  = 1;
	localparam int CMD_START_C = 2;
	localparam int CMD_STOP_C  = 3;
	localparam int CFG_B_AUTO  = 0;
	localparam int CFG_B_SLOW  = 1;
	localparam int STAT_C      = 0;
	localparam int STAT_B      = 1;
	localparam int STAT_W      = 2;

	// -------------------------------------------------------------
	// Types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		START_NONE, START_TX_END, START_TRIM_NO_UF, START_TRIM_UF
	} start_mode_t;

	typedef enum logic [1:0] {
		CLK_FAST, CLK_SLOW, CLK_A_UF, CLK_B_UF
	} clock_select_t;

	typedef struct packed {
		logic          stop_on_receive;
		logic          reserved_hi;
		start_mode_t   start_mode;
		logic          auto_restart;
		logic          reserved_lo;
		clock_select_t clock_select;
	} ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic [31:0] acc;
		logic        tick;
	} tick_state_t;

	typedef struct packed {
		logic [15:0] count;
		logic        running;
		logic        underflow;
	} core_state_t;

	typedef struct packed {
		ctrl_t             c_ctrl;
		logic [7:0]        c_rel_hi;
		logic [7:0]        c_rel_lo;
		logic [7:0]        b_rel_hi;
		logic [7:0]        b_rel_lo;
		logic              b_auto;
		logic              b_slow;
		logic [STAT_W-1:0] status;
		logic [STAT_W-1:0] enable;
		logic [2:0]        trim_sync;
		logic              trim_level;
		logic [7:0]        rd_data;
		logic              irq;
		logic              start_b;
		logic              stop_b;
		logic              start_c;
		logic              stop_c;
	} top_state_t;

endpackage

// File: src/tick_source.sv
`timescale 1ns/10ps

module tick_source #(
	parameter int RATE_KHZ = timer_pair_pkg::FAST_KHZ
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	output logic      tick
);

	timer_pair_pkg::tick_state_t st_reg;
	timer_pair_pkg::tick_state_t st_next;
	logic [31:0]                 sum;

	// -------------------------------------------------------------
	// Parameter check
	// -------------------------------------------------------------
	if (RATE_KHZ <= 0 || RATE_KHZ > timer_pair_pkg::SYS_KHZ) begin : g_bad
		$error("tick rate must lie between zero and the system rate");
	end

	// -------------------------------------------------------------
	// Fractional accumulator
	// -------------------------------------------------------------
	// Average rate is exact; single ticks jitter by one cycle
	always_comb begin
		st_next = st_reg;
		sum     = st_reg.acc + 32'(RATE_KHZ);
		if (sum >= 32'(timer_pair_pkg::SYS_KHZ)) begin
			st_next.acc  = sum - 32'(timer_pair_pkg::SYS_KHZ);
			st_next.tick = 1'b1;
		end else begin
			st_next.acc  = sum;
			st_next.tick = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;

endmodule

// File: src/countdown_core.sv
`timescale 1ns/10ps

module countdown_core (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        start,
	input  wire logic        stop,
	input  wire logic        tick,
	input  wire logic        auto_restart,
	input  wire logic        allow_underflow,
	input  wire logic [15:0] reload,
	output logic [15:0]      count,
	output logic             running,
	output logic             underflow
);

	timer_pair_pkg::core_state_t st_reg;
	timer_pair_pkg::core_state_t st_next;

	// -------------------------------------------------------------
	// Countdown
	// -------------------------------------------------------------
	// Start wins over stop, stop wins over a tick
	always_comb begin
		st_next           = st_reg;
		st_next.underflow = 1'b0;
		if (start) begin
			st_next.count   = reload;
			st_next.running = 1'b1;
		end else if (stop) begin
			st_next.running = 1'b0;
		end else if (st_reg.running && tick) begin
			if (st_reg.count != 16'h0000) begin
				st_next.count = st_reg.count - 16'h0001;
			end else begin
				st_next.underflow = allow_underflow;
				if (auto_restart && allow_underflow) begin
					st_next.count = reload;
				end else begin
					st_next.running = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign count     = st_reg.count;
	assign running   = st_reg.running;
	assign underflow = st_reg.underflow;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_start_loads: assert property (
		start |=> running && count == $past(reload))
		else $error("start did not load the reload value");
	chk_decrement_one: assert property (
		(!start && !stop && running && tick && count != 16'h0000)
		|=> count == $past(count) - 16'h0001 && running)
		else $error("count did not step down by one");
	chk_auto_reload: assert property (
		(!start && !stop && running && tick && count == 16'h0000
		 && auto_restart && allow_underflow)
		|=> running && underflow && count == $past(reload))
		else $error("auto restart did not reload");
	chk_one_shot_stop: assert property (
		(!start && !stop && running && tick && count == 16'h0000
		 && !auto_restart)
		|=> !running ##1 (!running || $past(start)))
		else $error("one shot timer kept running");

endmodule

// File: src/cascadable_timer_pair_regs.sv
`timescale 1ns/10ps

// Operation
// - B reload low used only at start or auto restart
// - B start loads high and low reload
// - B count readable live, high then low
// - C stop bit halts on first bits
// - Trimming modes ignore the stop bit
// - Mode 00 manual, 01 starts after transmit
// - Modes 10/11 trim on signal rising edges
// - Auto restart reloads at zero, keeps counting, except C in mode 10
// - Without auto restart, stop at zero
// - Every C underflow sets its flag
// - Clock select 00 fast, 01 slow tick
// - Clock select 10/11 counts A/B underflows
// - C start loads sixteen bit reload
// - C reload writes wait for next start or auto restart
module cascadable_timer_pair_regs (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire timer_pair_pkg::reg_req_t  bus_req,
	input  wire logic                      tx_end,
	input  wire logic                      rx_first_bits,
	input  wire logic                      timer_a_underflow,
	input  wire logic                      trim_in,
	output logic [7:0]                     rd_data,
	output logic                           irq,
	output logic                           timer_b_underflow,
	output logic                           timer_c_underflow
);

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	localparam int STAT_W_L = timer_pair_pkg::STAT_W;

	timer_pair_pkg::top_state_t st_reg;
	timer_pair_pkg::top_state_t st_next;
	logic                       fast_tick;
	logic                       slow_tick;
	logic                       tick_b;
	logic                       tick_c;
	logic [15:0]                b_count;
	logic [15:0]                c_count;
	logic                       b_running;
	logic                       c_running;
	logic [15:0]                b_reload;
	logic [15:0]                c_reload;
	logic [7:0]                 b_hi;
	logic [7:0]                 b_lo;
	logic                       is_trim;
	logic                       trim_stable;
	logic                       trim_rise;
	logic                       wr_cmd;
	logic [STAT_W_L-1:0]        irq_set;
	logic [STAT_W_L-1:0]        irq_clr;

	// -------------------------------------------------------------
	// Tick selection
	// -------------------------------------------------------------
	// Picks the decrement clock for one timer
	function automatic logic sel_tick(
		input timer_pair_pkg::clock_select_t sel,
		input logic                          fast,
		input logic                          slow,
		input logic                          a_uf,
		input logic                          b_uf
	);
		logic t;
		t = 1'b0;
		unique case (sel)
			timer_pair_pkg::CLK_FAST: t = fast;
			timer_pair_pkg::CLK_SLOW: t = slow;
			timer_pair_pkg::CLK_A_UF: t = a_uf;
			timer_pair_pkg::CLK_B_UF: t = b_uf;
		endcase
		return t;
	endfunction

	// -------------------------------------------------------------
	// Tick sources
	// -------------------------------------------------------------
	tick_source #(
		.RATE_KHZ (timer_pair_pkg::FAST_KHZ)
	) u_fast_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (fast_tick)
	);

	tick_source #(
		.RATE_KHZ (timer_pair_pkg::SLOW_KHZ)
	) u_slow_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (slow_tick)
	);

	// Timer B ticks from the fast or slow source
	assign tick_b = sel_tick(
		st_reg.b_slow ? timer_pair_pkg::CLK_SLOW
		              : timer_pair_pkg::CLK_FAST,
		fast_tick, slow_tick, timer_a_underflow, 1'b0);

	// Timer C may cascade on A or B underflows
	assign tick_c = sel_tick(st_reg.c_ctrl.clock_select,
		fast_tick, slow_tick, timer_a_underflow,
		timer_b_underflow);

	// -------------------------------------------------------------
	// Reload values
	// -------------------------------------------------------------
	// Reload bytes only reach a counter on a start or auto restart
	assign b_reload = {st_reg.b_rel_hi, st_reg.b_rel_lo};
	assign c_reload = {st_reg.c_rel_hi, st_reg.c_rel_lo};
	assign b_hi     = b_count[15:8];
	assign b_lo     = b_count[7:0];

	// -------------------------------------------------------------
	// Timers
	// -------------------------------------------------------------
	countdown_core u_timer_b (
		.clk             (clk),
		.sys_rst         (sys_rst),
		.start           (st_reg.start_b),
		.stop            (st_reg.stop_b),
		.tick            (tick_b),
		.auto_restart    (st_reg.b_auto),
		.allow_underflow (1'b1),
		.reload          (b_reload),
		.count           (b_count),
		.running         (b_running),
		.underflow       (timer_b_underflow)
	);

	countdown_core u_timer_c (
		.clk             (clk),
		.sys_rst         (sys_rst),
		.start           (st_reg.start_c),
		.stop            (st_reg.stop_c),
		.tick            (tick_c),
		.auto_restart    (st_reg.c_ctrl.auto_restart),
		.allow_underflow (st_reg.c_ctrl.start_mode !=
		                  timer_pair_pkg::START_TRIM_NO_UF),
		.reload          (c_reload),
		.count           (c_count),
		.running         (c_running),
		.underflow       (timer_c_underflow)
	);

	// -------------------------------------------------------------
	// Trim input and event decode
	// -------------------------------------------------------------
	// A change counts once the second and third stages agree
	assign trim_stable = st_reg.trim_sync[1] == st_reg.trim_sync[2];
	assign trim_rise   = trim_stable && st_reg.trim_sync[2] &&
	                     !st_reg.trim_level;
	assign is_trim     = st_reg.c_ctrl.start_mode[1];
	assign wr_cmd      = bus_req.wr &&
	                     bus_req.addr == timer_pair_pkg::ADDR_COMMAND;
	assign irq_set     = {timer_b_underflow, timer_c_underflow};
	assign irq_clr     = (bus_req.wr && bus_req.addr ==
	                      timer_pair_pkg::ADDR_IRQ_CLEAR)
	                     ? bus_req.wdata[STAT_W_L-1:0] : '0;

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb begin
		st_next           = st_reg;
		st_next.trim_sync = {st_reg.trim_sync[1:0], trim_in};
		if (trim_stable) begin
			st_next.trim_level = st_reg.trim_sync[2];
		end

		// Register writes
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				timer_pair_pkg::ADDR_B_RELOAD_HIGH:
					st_next.b_rel_hi = bus_req.wdata;
				timer_pair_pkg::ADDR_B_RELOAD_LOW:
					st_next.b_rel_lo = bus_req.wdata;
				timer_pair_pkg::ADDR_C_CONTROL:
					st_next.c_ctrl = ctrl_t_cast(bus_req.wdata &
						timer_pair_pkg::CTRL_WMASK);
				timer_pair_pkg::ADDR_C_RELOAD_HIGH:
					st_next.c_rel_hi = bus_req.wdata;
				timer_pair_pkg::ADDR_C_RELOAD_LOW:
					st_next.c_rel_lo = bus_req.wdata;
				timer_pair_pkg::ADDR_B_CONFIG: begin
					st_next.b_auto =
						bus_req.wdata[timer_pair_pkg::CFG_B_AUTO];
					st_next.b_slow =
						bus_req.wdata[timer_pair_pkg::CFG_B_SLOW];
				end
				timer_pair_pkg::ADDR_IRQ_ENABLE:
					st_next.enable = bus_req.wdata[STAT_W_L-1:0];
				default: ;
			endcase
		end

		// Timer B start and stop come from software only
		st_next.start_b = wr_cmd &&
			bus_req.wdata[timer_pair_pkg::CMD_START_B];
		st_next.stop_b  = wr_cmd &&
			bus_req.wdata[timer_pair_pkg::CMD_STOP_B];

		// Timer C start: software, end of transmit, or trim edge
		st_next.start_c =
			(wr_cmd && bus_req.wdata[timer_pair_pkg::CMD_START_C]) ||
			(tx_end && st_reg.c_ctrl.start_mode ==
			 timer_pair_pkg::START_TX_END) ||
			(is_trim && trim_rise && !c_running);

		// Timer C stop: software, trim edge, or first bits received
		st_next.stop_c =
			(wr_cmd && bus_req.wdata[timer_pair_pkg::CMD_STOP_C]) ||
			(is_trim && trim_rise && c_running) ||
			(rx_first_bits && st_reg.c_ctrl.stop_on_receive &&
			 !is_trim);

		// Sticky flags; a set in the clearing cycle survives
		st_next.status = (st_reg.status & ~irq_clr) | irq_set;
		st_next.irq    = |(st_reg.status & st_reg.enable);

		// Read data stands for one cycle only; counts are live
		st_next.rd_data = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				timer_pair_pkg::ADDR_B_RELOAD_HIGH:
					st_next.rd_data = st_reg.b_rel_hi;
				timer_pair_pkg::ADDR_B_RELOAD_LOW:
					st_next.rd_data = st_reg.b_rel_lo;
				timer_pair_pkg::ADDR_B_COUNT_HIGH:
					st_next.rd_data = b_hi;
				timer_pair_pkg::ADDR_B_COUNT_LOW:
					st_next.rd_data = b_lo;
				timer_pair_pkg::ADDR_C_CONTROL:
					st_next.rd_data = 8'(st_reg.c_ctrl);
				timer_pair_pkg::ADDR_C_RELOAD_HIGH:
					st_next.rd_data = st_reg.c_rel_hi;
				timer_pair_pkg::ADDR_C_RELOAD_LOW:
					st_next.rd_data = st_reg.c_rel_lo;
				timer_pair_pkg::ADDR_B_CONFIG:
					st_next.rd_data = {6'h00, st_reg.b_slow,
					                   st_reg.b_auto};
				timer_pair_pkg::ADDR_IRQ_STATUS:
					st_next.rd_data = {6'h00, st_reg.status};
				timer_pair_pkg::ADDR_IRQ_ENABLE:
					st_next.rd_data = {6'h00, st_reg.enable};
				default:
					st_next.rd_data = 8'h00;
			endcase
		end
	end

	// Turns a masked byte into the control layout
	function automatic timer_pair_pkg::ctrl_t ctrl_t_cast(
		input logic [7:0] v
	);
		return timer_pair_pkg::ctrl_t'(v);
	endfunction

	// -------------------------------------------------------------
	// State register
	// -------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg          <= '0;
			st_reg.c_ctrl   <= timer_pair_pkg::ctrl_t'(
			                   timer_pair_pkg::CTRL_RESET);
			st_reg.c_rel_hi <= timer_pair_pkg::RELOAD_RESET;
			st_reg.c_rel_lo <= timer_pair_pkg::RELOAD_RESET;
			st_reg.b_rel_hi <= timer_pair_pkg::RELOAD_RESET;
			st_reg.b_rel_lo <= timer_pair_pkg::RELOAD_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data = st_reg.rd_data;
	assign irq     = st_reg.irq;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_b_reload_deferred: assert property (
		(b_running && bus_req.wr && !st_reg.start_b &&
		 bus_req.addr == timer_pair_pkg::ADDR_B_RELOAD_LOW)
		|=> (b_count == $past(b_count) ||
		     b_count == $past(b_count) - 16'h0001 ||
		     b_count == $past(b_reload)))
		else $error("reload low write disturbed a running count");

	chk_b_start_load: assert property (
		st_reg.start_b |=> b_count == $past(b_reload))
		else $error("timer B start did not load both bytes");

	chk_b_count_high: assert property (
		(bus_req.rd && bus_req.addr == timer_pair_pkg::ADDR_B_COUNT_HIGH)
		|=> rd_data == $past(b_hi))
		else $error("count high readback wrong");

	chk_b_count_low: assert property (
		(bus_req.rd && bus_req.addr == timer_pair_pkg::ADDR_B_COUNT_LOW)
		|=> rd_data == $past(b_lo))
		else $error("count low readback wrong");

	chk_stop_on_rx: assert property (
		(rx_first_bits && st_reg.c_ctrl.stop_on_receive && !is_trim &&
		 !tx_end && !wr_cmd)
		|=> st_reg.stop_c && !st_reg.start_c ##1 !c_running)
		else $error("timer C did not halt on first bits");

	chk_trim_ignores_rx: assert property (
		(rx_first_bits && is_trim && !trim_rise && !wr_cmd)
		|=> !st_reg.stop_c)
		else $error("stop on receive acted in trim mode");

	chk_tx_end_start: assert property (
		(tx_end && st_reg.c_ctrl.start_mode ==
		 timer_pair_pkg::START_TX_END)
		|=> st_reg.start_c ##1 c_running)
		else $error("timer C did not start after transmit");

	chk_trim_edge: assert property (
		(is_trim && trim_rise && !wr_cmd)
		|=> (st_reg.start_c != st_reg.stop_c) ##1
		    (c_running != $past(c_running, 2)))
		else $error("trim edge did not toggle timer C");

	chk_c_flag_set: assert property (
		timer_c_underflow |=> st_reg.status[timer_pair_pkg::STAT_C])
		else $error("timer C underflow did not set its flag");

	chk_cascade_tick: assert property (
		(st_reg.c_ctrl.clock_select == timer_pair_pkg::CLK_B_UF &&
		 c_running && timer_b_underflow && c_count != 16'h0000 &&
		 !st_reg.start_c && !st_reg.stop_c)
		|=> c_count == $past(c_count) - 16'h0001)
		else $error("timer C missed a cascaded tick");

	chk_c_start_load: assert property (
		st_reg.start_c |=> c_count == $past(c_reload) && c_running)
		else $error("timer C start did not load reload");

	chk_c_reload_deferred: assert property (
		(c_running && bus_req.wr && !st_reg.start_c &&
		 bus_req.addr == timer_pair_pkg::ADDR_C_RELOAD_LOW)
		|=> (c_count == $past(c_count) ||
		     c_count == $past(c_count) - 16'h0001 ||
		     c_count == $past(c_reload)))
		else $error("reload write disturbed timer C");

	chk_reserved_zero: assert property (
		(st_reg.c_ctrl.reserved_hi == 1'b0 &&
		 st_reg.c_ctrl.reserved_lo == 1'b0))
		else $error("reserved control bits took a value");

	cov_c_auto_restart: cover property (
		timer_c_underflow && c_running);
	cov_cascade: cover property (
		st_reg.c_ctrl.clock_select == timer_pair_pkg::CLK_B_UF &&
		timer_b_underflow && c_running);
	cov_trim_start: cover property (
		is_trim && trim_rise ##2 c_running);
	cov_irq_raised: cover property (!irq ##1 irq);

endmodule

// File: verification/testbench.sv
`timescale 1ns/10ps

module testbench;

	logic                     clk;
	logic                     sys_rst;
	timer_pair_pkg::reg_req_t req;
	logic                     tx_end;
	logic                     rx_first_bits;
	logic                     a_uf;
	logic [7:0]               rd_data;
	logic                     irq;
	logic                     trim;
	logic                     b_uf;
	logic                     c_uf;
	logic [7:0]               got;
	int                       failures;
	int                       n_checks;
	int                       cycles;
	int                       n_b_uf;
	int                       n_c_uf;

	cascadable_timer_pair_regs cascadable_timer_pair_regs_i (
		.clk               (clk),
		.sys_rst           (sys_rst),
		.bus_req           (req),
		.tx_end            (tx_end),
		.rx_first_bits     (rx_first_bits),
		.timer_a_underflow (a_uf),
		.trim_in           (trim),
		.rd_data           (rd_data),
		.irq               (irq),
		.timer_b_underflow (b_uf),
		.timer_c_underflow (c_uf)
	);

	// ------------------------------------------------------------
	// Clock, timeout and bus tasks
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Counts underflow pulses and cuts a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (b_uf === 1'b1) begin
			n_b_uf <= n_b_uf + 1;
		end
		if (c_uf === 1'b1) begin
			n_c_uf <= n_c_uf + 1;
		end
		if (cycles == 5000) begin
			failures = failures + 1;
			final_report();
		end
	end

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] seen);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 got = rd_data;
	endtask

	// Timer A underflow pulses, used as the cascade tick of timer C
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			a_uf <= 1'b1;
			@(posedge clk);
			a_uf <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		wr(8'h19, 8'hFF);
		rd(8'h19);
		check("control", 8'hBB, got);
		wr(8'h1A, 8'h00);
		wr(8'h1B, 8'h03);
		rd(8'h1B);
		check("c reload low", 8'h03, got);
		rd(8'h40);
		check("unmapped", 8'h00, got);
		wr(8'h18, 8'h55);
		rd(8'h18);
		check("b count ro", 8'h00, got);
		$display("test regs done");
	endtask

	task automatic t_timer_b;
		wr(8'h15, 8'h12);
		wr(8'h16, 8'h34);
		rd(8'h16);
		check("b reload low", 8'h34, got);
		wr(8'h30, 8'h01);
		wr(8'h16, 8'h01);
		rd(8'h17);
		check("b count high", 8'h12, got);
		wr(8'h30, 8'h02);
		wr(8'h15, 8'h00);
		wr(8'h31, 8'h01);
		wr(8'h19, 8'h03);
		wr(8'h30, 8'h05);
		repeat (60) @(posedge clk);
		wr(8'h30, 8'h02);
		rd(8'h32);
		check("cascade on b", 8'h03, got);
		check("b underflows", 8'h01, {7'h00, (n_b_uf >= 4)});
		check("c underflows", 8'h01, 8'(n_c_uf));
		wr(8'h33, 8'h03);
		$display("test timer b done");
	endtask

	task automatic t_cascade;
		wr(8'h19, 8'h0A);
		wr(8'h34, 8'h01);
		wr(8'h30, 8'h04);
		repeat (3) @(posedge clk);
		pulses(1);
		rd(8'h1B);
		check("c reload low", 8'h03, got);
		wr(8'h1B, 8'h05);
		rd(8'h1B);
		check("c reload new", 8'h05, got);
		pulses(3);
		rd(8'h32);
		check("status", 8'h01, got);
		check("irq", 8'h01, {7'h00, irq});
		check("c underflows", 8'h02, 8'(n_c_uf));
		wr(8'h33, 8'h01);
		repeat (2) @(posedge clk);
		check("irq cleared", 8'h00, {7'h00, irq});
		pulses(6);
		check("c restarts", 8'h03, 8'(n_c_uf));
		wr(8'h30, 8'h08);
		$display("test cascade done");
	endtask

	// One-cycle pulse on the transmit-end or the first-bits event
	task automatic event_pulse(input logic tx);
		@(posedge clk);
		tx_end        <= tx;
		rx_first_bits <= !tx;
		@(posedge clk);
		tx_end        <= 1'b0;
		rx_first_bits <= 1'b0;
	endtask

	// Rising edge on the trimmed signal, held past the synchroniser
	task automatic trim_edge;
		@(posedge clk);
		trim <= 1'b1;
		repeat (6) @(posedge clk);
		trim <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	// Timer C has no count readback here: its count shows in its flag
	task automatic t_count;
		wr(8'h33, 8'h01);
		wr(8'h19, 8'h02);
		wr(8'h1B, 8'h03);
		wr(8'h30, 8'h04);
		pulses(1);
		wr(8'h1B, 8'h07);
		pulses(2);
		rd(8'h32);
		check("status at zero", 8'h00, got);
		pulses(1);
		rd(8'h32);
		check("status one shot", 8'h01, got);
		wr(8'h33, 8'h01);
		pulses(1);
		rd(8'h32);
		check("one shot end", 8'h00, got);
		wr(8'h19, 8'h92);
		event_pulse(1'b1);
		pulses(7);
		rd(8'h32);
		check("tx end count", 8'h00, got);
		pulses(1);
		rd(8'h32);
		check("tx end start", 8'h01, got);
		wr(8'h33, 8'h01);
		event_pulse(1'b1);
		pulses(2);
		event_pulse(1'b0);
		pulses(6);
		rd(8'h32);
		check("stopped on rx", 8'h00, got);
		wr(8'h30, 8'h04);
		pulses(4);
		wr(8'h30, 8'h04);
		pulses(7);
		rd(8'h32);
		check("restart", 8'h00, got);
		pulses(1);
		rd(8'h32);
		check("restart end", 8'h01, got);
		$display("test count done");
	endtask

	task automatic t_trim;
		wr(8'h33, 8'h01);
		wr(8'h19, 8'hB2);
		trim_edge();
		event_pulse(1'b0);
		pulses(8);
		rd(8'h32);
		check("trim start", 8'h01, got);
		wr(8'h33, 8'h01);
		trim_edge();
		trim_edge();
		pulses(8);
		rd(8'h32);
		check("trim stop", 8'h00, got);
		$display("test trim done");
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		sys_rst = 1'b1;
		req = '0;
		tx_end = 1'b0;
		rx_first_bits = 1'b0;
		a_uf = 1'b0;
		trim = 1'b0;
		n_b_uf = 0;
		n_c_uf = 0;
		failures = 0;
		n_checks = 0;
		cycles = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_timer_b();
		t_cascade();
		t_count();
		t_trim();
		final_report();
	end

endmodule
